// File: src/sarseq_pkg.sv
// constants, register map and types of the conversion sequencer
package sarseq_pkg;

   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL_A = 8'h00;
   localparam logic [7:0] OFS_CTRL_B = 8'h04;
   localparam logic [7:0] OFS_CHAN   = 8'h08;
   localparam logic [7:0] OFS_REFGN  = 8'h0C;
   localparam logic [7:0] OFS_RES_L  = 8'h10;
   localparam logic [7:0] OFS_RES_H  = 8'h14;
   localparam logic [7:0] OFS_PWR    = 8'h18;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int A_PS_LSB = 0;
   localparam int A_PS_MSB = 2;
   localparam int A_FLAG   = 4;
   localparam int A_AUTO   = 5;
   localparam int A_START  = 6;
   localparam int A_EN     = 7;
   localparam int B_TS_MSB = 2;
   localparam int B_LADJ   = 3;
   localparam int P_PRR    = 0;

   // ------------------------------------------------------------
   // timing in converter clock cycles, counted in half cycles
   // ------------------------------------------------------------
   localparam int NORM_CYC  = 15;
   localparam int NORM_SH   = 4;
   localparam int FIRST_CYC = 26;
   localparam int FIRST_SH  = 15;
   localparam logic [5:0] NORM_LAST  = 6'(2 * NORM_CYC - 1);
   localparam logic [5:0] NORM_SHH   = 6'(2 * NORM_SH);
   localparam logic [5:0] FIRST_LAST = 6'(2 * FIRST_CYC - 1);
   localparam logic [5:0] FIRST_SHH  = 6'(2 * FIRST_SH);
   localparam logic [2:0] TS_SELF    = 3'h0;
   localparam logic [1:0] RESP_OK    = 2'h0;
   localparam logic [1:0] RESP_ERR   = 2'h2;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [5:0] ch;
      logic [2:0] reference_select_field;
      logic [1:0] gain;
   } sarseq_sel_t;

endpackage

// File: src/sarseq_top.sv
// conversion sequencer for a 10-bit successive approximation converter
//
// How it works
// - channel and reference selections reach the analog side only while enabled.
// - 10-bit result split over high and low bytes, right or left adjusted.
// - reading low byte locks both bytes until high byte is read; results lost meanwhile.
// - completion flag still sets when a result is discarded by the lock.
// - writing start begins one conversion; start reads one until it completes.
// - channel change during a conversion only takes effect after it.
// - auto-trigger rising edge resets the prescaler and starts a conversion.
// - trigger level at completion does not restart; edges during conversion ignored.
// - own completion flag as trigger gives continuous conversion after first start.
// - start write works in auto mode; start reads one during any conversion.
// - prescaler divides core clock, runs while enabled, held in reset otherwise.
// - a start write begins at the next rising converter clock edge.
// - normal conversion 15 converter cycles, sample-and-hold after 4.
// - first conversion after enable 26 cycles, sample-and-hold after 15.
// - with gain active, first conversion after a selection change is long too, except a free running restart.
// - completion writes results, sets flag, clears start in the same cycle.
// - auto-triggered conversion samples at 4.5 cycles and lasts 15.5 cycles.
// - free running restarts at once after completion, start stays high.
// - selections copied while idle, frozen during conversion, resumed at completion.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module sarseq_top
   import sarseq_pkg::*;
#(
   parameter int TRIG_N = 8
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 nrst,
   // axi4-lite write
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output      logic                 s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output      logic                 s_axi_wready,
   output      logic [1:0]           s_axi_bresp,
   output      logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output      logic                 s_axi_arready,
   output      logic [31:0]          s_axi_rdata,
   output      logic [1:0]           s_axi_rresp,
   output      logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // trigger sources, bit 0 unused
   input  wire logic [TRIG_N-1:0]    trig_src,
   // analog side
   input  wire logic [9:0]           sar_data,
   output      sarseq_pkg::sarseq_sel_t sel_apply,
   output      logic                 analog_on,
   output      logic                 conv_busy,
   output      logic                 hold_pulse,
   output      logic                 conversion_complete_flag
);
   import sarseq_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SQ_IDLE = 2'b01,
      SQ_CONV = 2'b10
   } sarseq_st_t;

   sarseq_st_t  st_q;
   sarseq_sel_t buf_q, last_q, sel_q;
   logic [2:0]  ps_q, ts_q;
   logic        en_q, auto_q, ladj_q, prr_q, flag_q;
   logic        pend_q, first_q, lock_q, on_q, hold_q;
   logic [6:0]  pre_q;
   logic        phase_q;
   logic [5:0]  hcnt_q, last_h_q, sh_q;
   logic [7:0]  resh_q, resl_q;
   logic [2:0]  tsync_q;
   logic        awr_q, bv_q, arr_q, rv_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   function automatic logic [6:0] half_div(input logic [2:0] ps);
      half_div = (ps == 3'h0) ? 7'h01 : 7'(7'h01 << (ps - 3'h1));
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_CTRL_A) || (a == OFS_CTRL_B) || (a == OFS_CHAN) ||
               (a == OFS_REFGN) || (a == OFS_RES_L) || (a == OFS_RES_H) ||
               (a == OFS_PWR);
   endfunction

   wire        busy     = (st_q == SQ_CONV);
   wire        en_eff   = en_q & ~prr_q;
   wire        htick    = en_eff & (pre_q == half_div(ps_q) - 7'h01);
   wire        rise     = htick & ~phase_q;
   wire        done     = busy & htick & (hcnt_q == last_h_q);
   wire        free_run = auto_q & (ts_q == TS_SELF);
   wire        t_edge   = tsync_q[1] & ~tsync_q[2];
   // edges while converting or from the own flag never start anything
   wire        trig_go  = auto_q & en_eff & ~busy & (ts_q != TS_SELF) & t_edge;
   wire        single   = pend_q & rise & ~busy & ~trig_go;
   wire        go       = trig_go | single;
   wire        chg      = (buf_q.gain != 2'h0) & (buf_q != last_q);
   wire        long_c   = first_q | chg;
   wire        restart  = done & free_run & en_eff;
   wire [15:0] fmt      = ladj_q ? {sar_data, 6'h00} : {6'h00, sar_data};

   wire        wr_hs    = s_axi_awvalid & awr_q;
   wire        we       = wr_hs & s_axi_wstrb[0];
   wire [7:0]  wv       = s_axi_wdata[7:0];
   wire        rd_hs    = s_axi_arvalid & arr_q;
   wire        we_a     = we & (s_axi_awaddr == OFS_CTRL_A);
   wire        clr_flag = we_a & wv[A_FLAG];
   wire        rd_l     = rd_hs & (s_axi_araddr == OFS_RES_L);
   wire        rd_h     = rd_hs & (s_axi_araddr == OFS_RES_H);
   wire        start_rd = pend_q | busy;

   wire [7:0]  rd_val =
      (s_axi_araddr == OFS_CTRL_A) ? {en_q, start_rd, auto_q, flag_q, 1'b0, ps_q} :
      (s_axi_araddr == OFS_CTRL_B) ? {4'h0, ladj_q, ts_q} :
      (s_axi_araddr == OFS_CHAN)   ? {2'h0, buf_q.ch} :
      (s_axi_araddr == OFS_REFGN)  ? {3'h0, buf_q.reference_select_field, buf_q.gain} :
      (s_axi_araddr == OFS_RES_L)  ? resl_q :
      (s_axi_araddr == OFS_RES_H)  ? resh_q :
      (s_axi_araddr == OFS_PWR)    ? {7'h00, prr_q} : 8'h00;

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         awr_q   <= 1'b0;
         bv_q    <= 1'b0;
         bresp_q <= RESP_OK;
      end else begin
         awr_q <= s_axi_awvalid & s_axi_wvalid & ~awr_q & ~bv_q;
         if (wr_hs) begin
            bv_q    <= 1'b1;
            bresp_q <= mapped(s_axi_awaddr) ? RESP_OK : RESP_ERR;
         end else if (s_axi_bready) begin
            bv_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         arr_q   <= 1'b0;
         rv_q    <= 1'b0;
         rresp_q <= RESP_OK;
         rdata_q <= 32'h0;
      end else begin
         arr_q <= s_axi_arvalid & ~arr_q & ~rv_q;
         if (rd_hs) begin
            rv_q    <= 1'b1;
            rdata_q <= {24'h0, rd_val};
            rresp_q <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
         end else if (s_axi_rready) begin
            rv_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         en_q   <= 1'b0;
         auto_q <= 1'b0;
         ps_q   <= 3'h0;
         ts_q   <= 3'h0;
         ladj_q <= 1'b0;
         prr_q  <= 1'b0;
         buf_q  <= '0;
      end else if (we) begin
         unique case (s_axi_awaddr)
            OFS_CTRL_A: begin
               en_q   <= wv[A_EN];
               auto_q <= wv[A_AUTO];
               ps_q   <= wv[A_PS_MSB:A_PS_LSB];
            end
            OFS_CTRL_B: begin
               ts_q   <= wv[B_TS_MSB:0];
               ladj_q <= wv[B_LADJ];
            end
            OFS_CHAN:  buf_q.ch <= wv[5:0];
            OFS_REFGN: begin
               buf_q.reference_select_field <= wv[4:2];
               buf_q.gain <= wv[1:0];
            end
            OFS_PWR:   prr_q <= wv[P_PRR];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // prescaler and trigger synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pre_q   <= 7'h00;
         phase_q <= 1'b0;
         tsync_q <= 3'h0;
      end else begin
         tsync_q <= {tsync_q[1:0], trig_src[ts_q]};
         // a trigger realigns the converter clock to a fixed delay
         if (!en_eff || trig_go) begin
            pre_q   <= 7'h00;
            phase_q <= 1'b0;
         end else if (htick) begin
            pre_q   <= 7'h00;
            phase_q <= ~phase_q;
         end else begin
            pre_q <= pre_q + 7'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // conversion sequence
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_q     <= SQ_IDLE;
         hcnt_q   <= 6'h00;
         last_h_q <= NORM_LAST;
         sh_q     <= NORM_SHH;
         pend_q   <= 1'b0;
         first_q  <= 1'b1;
         last_q   <= '0;
         hold_q   <= 1'b0;
      end else if (!en_eff) begin
         st_q    <= SQ_IDLE;
         pend_q  <= 1'b0;
         first_q <= 1'b1;
         hold_q  <= 1'b0;
      end else begin
         // decided one half tick early: the pulse flop adds the last step
         hold_q <= busy & htick & (hcnt_q == sh_q - 6'h01);
         if (we_a && wv[A_START] && wv[A_EN]) begin
            pend_q <= 1'b1;
         end else if (go) begin
            pend_q <= 1'b0;
         end
         if (go) begin
            st_q     <= SQ_CONV;
            hcnt_q   <= 6'h00;
            first_q  <= 1'b0;
            last_q   <= buf_q;
            // trigger starts half a cycle earlier than a clock edge
            last_h_q <= (long_c ? FIRST_LAST : NORM_LAST) + {5'h00, trig_go};
            sh_q     <= (long_c ? FIRST_SHH : NORM_SHH) + {5'h00, trig_go};
         end else if (restart) begin
            hcnt_q   <= 6'h00;
            last_h_q <= NORM_LAST;
            sh_q     <= NORM_SHH;
            last_q   <= buf_q;
         end else if (done) begin
            st_q <= SQ_IDLE;
         end else if (busy && htick) begin
            hcnt_q <= hcnt_q + 6'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // selections, results and flag
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sel_q  <= '0;
         on_q   <= 1'b0;
         flag_q <= 1'b0;
         lock_q <= 1'b0;
         resh_q <= 8'h00;
         resl_q <= 8'h00;
      end else begin
         on_q <= en_eff;
         if (!en_eff) begin
            sel_q <= '0;
         end else if (!busy || done) begin
            sel_q <= buf_q;
         end
         // set wins over a clear in the same cycle
         if (done) begin
            flag_q <= 1'b1;
         end else if (clr_flag) begin
            flag_q <= 1'b0;
         end
         if (done && !lock_q) begin
            resh_q <= fmt[15:8];
            resl_q <= fmt[7:0];
         end
         if (rd_l) begin
            lock_q <= 1'b1;
         end else if (rd_h) begin
            lock_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awr_q;
   assign s_axi_wready  = awr_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arr_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign sel_apply     = sel_q;
   assign analog_on     = on_q;
   assign conv_busy     = busy;
   assign hold_pulse    = hold_q;
   assign conversion_complete_flag = flag_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_off_sel;
      @(posedge core_clk) disable iff (!nrst)
      !en_eff |=> (sel_q == '0) && !busy;
   endproperty
   a_off_sel: assert property (p_off_sel) else $error("selection applied while off");

   property p_pair;
      @(posedge core_clk) disable iff (!nrst)
      done && !lock_q |=> {resh_q, resl_q} == $past(fmt);
   endproperty
   a_pair: assert property (p_pair) else $error("result bytes not updated");

   property p_lock;
      @(posedge core_clk) disable iff (!nrst)
      done && lock_q |=> $stable(resh_q) && $stable(resl_q);
   endproperty
   a_lock: assert property (p_lock) else $error("locked result changed");

   property p_flag;
      @(posedge core_clk) disable iff (!nrst)
      done && en_eff |=> flag_q;
   endproperty
   a_flag: assert property (p_flag) else $error("flag missing at completion");

   property p_hold_sel;
      @(posedge core_clk) disable iff (!nrst)
      busy && $past(busy) && en_eff && !$past(done) |-> $stable(sel_q);
   endproperty
   a_hold_sel: assert property (p_hold_sel) else $error("selection moved in conversion");

   property p_trig;
      @(posedge core_clk) disable iff (!nrst)
      trig_go |=> busy && (pre_q == 7'h00) && start_rd;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger did not start");

   property p_ignore;
      @(posedge core_clk) disable iff (!nrst)
      busy && !done && t_edge |=> hcnt_q == $past(hcnt_q) + {5'h00, $past(htick)};
   endproperty
   a_ignore: assert property (p_ignore) else $error("edge restarted conversion");

   property p_free;
      @(posedge core_clk) disable iff (!nrst)
      done && free_run && en_eff |=> busy && start_rd && (hcnt_q == 6'h00);
   endproperty
   a_free: assert property (p_free) else $error("free running stopped");

   property p_single;
      @(posedge core_clk) disable iff (!nrst)
      single && en_eff |=> busy && !pend_q;
   endproperty
   a_single: assert property (p_single) else $error("start not taken at edge");

   property p_pre_off;
      @(posedge core_clk) disable iff (!nrst)
      !en_eff |=> (pre_q == 7'h00) && !phase_q;
   endproperty
   a_pre_off: assert property (p_pre_off) else $error("prescaler ran while off");

   property p_end;
      @(posedge core_clk) disable iff (!nrst)
      done && !free_run && en_eff |=> !busy && flag_q && (!start_rd || pend_q);
   endproperty
   a_end: assert property (p_end) else $error("start bit not cleared");

endmodule

// File: verif/sarseq_analog_model.sv
// analog front end model feeding conversion results to the sequencer
`timescale 1ns/1ns
module sarseq_analog_model
   import sarseq_pkg::*;
(
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    nrst,
   // sequencer side
   input  wire logic                    conv_busy,
   input  wire logic                    hold_pulse,
   input  wire sarseq_pkg::sarseq_sel_t sel_apply,
   output      logic [9:0]              sar_data,
   output      logic [9:0]              held
);
   // ------------------------------------------------------------
   // sample at hold, keep the value until completion
   // ------------------------------------------------------------
   logic [9:0] v;
   // outside a conversion the line toggles, so a stale value never passes
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sar_data <= 10'h000;
         held     <= 10'h000;
      end else if (hold_pulse) begin
         v = 10'($urandom) ^ 10'(sel_apply.ch);
         sar_data <= v;
         held     <= v;
      end else if (!conv_busy) begin
         sar_data <= ~sar_data;
      end
   end
endmodule

// File: verif/sarseq_top_bench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module sarseq_top_bench;
   import sarseq_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        core_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        analog_on, conv_busy, hold_pulse, conversion_complete_flag;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, trig_src;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [9:0]  sar_data, held, d0;
   sarseq_sel_t sel_apply;
   logic [2:0]  ps, ts;
   logic [5:0]  ch;
   int          n_fail, tests_run, cyc, len, sh, lat, r, n;

   sarseq_top uut (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig_src, .sar_data,
      .sel_apply, .analog_on, .conv_busy, .hold_pulse, .conversion_complete_flag);
   sarseq_analog_model model (.core_clk, .nrst, .conv_busy, .hold_pulse, .sel_apply,
      .sar_data, .held);

   // ------------------------------------------------------------
   // clock, watchdog and helpers
   // ------------------------------------------------------------
   initial begin
      core_clk = 1'h0;
      forever #4 core_clk = ~core_clk;
   end
   // every wait below is bounded by this watchdog only
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude();
      if (n_fail == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [31:0] res(input logic [9:0] d, input logic la, input logic hi);
      logic [15:0] w;
      w = la ? {d, 6'h00} : {6'h00, d};
      return hi ? {24'h000000, w[15:8]} : {24'h000000, w[7:0]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do @(posedge core_clk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid  <= 1'h0;
      do @(posedge core_clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("write response", 32'(s_axi_bresp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] q);
      @(posedge core_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge core_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      d = s_axi_rdata;
      q = s_axi_rresp;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  q;
      rd(a, d, q);
      chk($sformatf("register %h", a), d, e);
   endtask
   // busy length and hold position are counted from the first cycle busy is seen
   task automatic conv(output int l, output int s, output int w);
      w = 0;
      l = 0;
      s = -1;
      do begin @(posedge core_clk); w++; end while (!conv_busy);
      while (conv_busy) begin
         if (hold_pulse && s < 0) s = l;
         l++;
         @(posedge core_clk);
      end
   endtask
   task automatic one(input int hl, input int hs, input logic [7:0] ctl, input logic mid);
      fork
         begin
            wr(OFS_CTRL_A, 32'(ctl), RESP_OK);
            if (mid) begin
               wr(OFS_CHAN, 32'(~ch), RESP_OK);
               chk("channel held", 32'(sel_apply.ch), 32'(ch));
               rd(OFS_CTRL_A, rv, rr);
               chk("start while busy", 32'(rv[A_START]), 32'h1);
               ch = ~ch;
            end
         end
         conv(len, sh, lat);
      join
      chk("busy length", 32'(len), 32'(hl * r));
      chk("hold position", 32'(sh), 32'(hs * r));
      chk("start latency", 32'(lat <= 5 + 2 * r), 32'h1);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      nrst = 1'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      trig_src = 8'h00;
      n_fail = 0;
      tests_run = 0;
      cyc = 0;
      void'($urandom(20));
      repeat (4) @(posedge core_clk);
      nrst <= 1'h1;
      rdchk(OFS_CTRL_A, 32'h00000000);
      rdchk(OFS_PWR, 32'h00000000);
      rd(8'h40, rv, rr);
      chk("unmapped read", 32'(rr), 32'(RESP_ERR));
      wr(8'h44, 32'h00000001, RESP_ERR);
      chk("inactive", 32'({analog_on, sel_apply}), 32'h00000000);
      ps = 3'($urandom_range(3));
      r = (ps < 2) ? 1 : (1 << (ps - 1));
      ch = 6'($urandom);
      wr(OFS_PWR, 32'h00000000, RESP_OK);
      wr(OFS_CHAN, 32'(ch), RESP_OK);
      wr(OFS_CTRL_A, 32'h80 | 32'(ps), RESP_OK);
      repeat (2) @(posedge core_clk);
      chk("enabled", 32'({analog_on, sel_apply.ch}), 32'({1'h1, ch}));
      // first conversion is long; later ones alternate adjust, and the last two move the channel
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CTRL_B, 32'(i[0]) << B_LADJ, RESP_OK);
         one(i == 0 ? 52 : 30, i == 0 ? 30 : 8, 8'hC0 | 8'(ps), i[1]);
         d0 = held;
         rdchk(OFS_CTRL_A, 32'h90 | 32'(ps));
         chk("flag pin", 32'(conversion_complete_flag), 32'h1);
         rdchk(OFS_RES_L, res(d0, i[0], 1'h0));
         rdchk(OFS_RES_H, res(d0, i[0], 1'h1));
         chk("channel after", 32'(sel_apply.ch), 32'(ch));
      end
      rdchk(OFS_RES_L, res(d0, 1'h1, 1'h0));
      wr(OFS_CTRL_A, 32'h90 | 32'(ps), RESP_OK);
      rdchk(OFS_CTRL_A, 32'h80 | 32'(ps));
      one(30, 8, 8'hC0 | 8'(ps), 1'h0);
      rdchk(OFS_CTRL_A, 32'h90 | 32'(ps));
      rdchk(OFS_RES_H, res(d0, 1'h1, 1'h1));
      rdchk(OFS_RES_L, res(d0, 1'h1, 1'h0));
      rdchk(OFS_RES_H, res(d0, 1'h1, 1'h1));
      // a write with the low byte lane off must leave the register alone
      s_axi_wstrb <= 4'h0;
      wr(OFS_PWR, 32'h00000001, RESP_OK);
      s_axi_wstrb <= 4'hF;
      rdchk(OFS_PWR, 32'h00000000);
      wr(OFS_REFGN, 32'h00000001, RESP_OK);
      one(52, 30, 8'hC0 | 8'(ps), 1'h0);
      one(30, 8, 8'hC0 | 8'(ps), 1'h0);
      wr(OFS_REFGN, 32'h00000000, RESP_OK);
      wr(OFS_CTRL_A, 32'h00000000, RESP_OK);
      wr(OFS_CTRL_A, 32'h80 | 32'(ps), RESP_OK);
      one(52, 30, 8'hC0 | 8'(ps), 1'h0);
      // auto trigger with a second edge inside the conversion
      ts = 3'($urandom_range(7, 1));
      wr(OFS_CTRL_B, 32'(ts), RESP_OK);
      wr(OFS_CTRL_A, 32'hA0 | 32'(ps), RESP_OK);
      fork
         begin
            repeat (3) @(posedge core_clk);
            trig_src[ts] <= 1'h1;
            repeat (12) @(posedge core_clk);
            trig_src[ts] <= 1'h0;
            @(posedge core_clk);
            trig_src[ts] <= 1'h1;
         end
         conv(len, sh, lat);
      join
      chk("trigger length", 32'(len), 32'(31 * r));
      chk("trigger hold", 32'(sh), 32'(9 * r));
      n = 0;
      repeat (40 * r) begin @(posedge core_clk); n += int'(conv_busy); end
      chk("no retrigger", 32'(n), 32'h0);
      trig_src[ts] <= 1'h0;
      one(30, 8, 8'hE0 | 8'(ps), 1'h0);
      wr(OFS_CTRL_B, 32'(TS_SELF), RESP_OK);
      wr(OFS_CTRL_A, 32'hE0 | 32'(ps), RESP_OK);
      n = 0;
      repeat (100 * r) begin @(posedge core_clk); n += int'(hold_pulse); end
      chk("free running", 32'(n >= 3), 32'h1);
      rd(OFS_CTRL_A, rv, rr);
      chk("start kept", 32'(rv[A_START]), 32'h1);
      wr(OFS_CTRL_A, 32'h80 | 32'(ps), RESP_OK);
      while (conv_busy) @(posedge core_clk);
      wr(OFS_PWR, 32'h00000001, RESP_OK);
      repeat (2) @(posedge core_clk);
      chk("power reduced", 32'({analog_on, sel_apply}), 32'h00000000);
      conclude();
   end
endmodule
